// file: logic/vcc_pkg.sv
// constants and types shared by the execution-control capability check block
package vcc_pkg;

	// ****************************************
	// register indices
	// ****************************************
	localparam logic [31:0] VCC_IDX_PIN = 32'h0000_0481;
	localparam logic [31:0] VCC_IDX_PRIMARY = 32'h0000_0482;
	localparam logic [31:0] VCC_IDX_SECONDARY = 32'h0000_048b;
	localparam logic [31:0] VCC_IDX_PIN_FULL = 32'h0000_048d;
	localparam logic [31:0] VCC_IDX_PRIMARY_FULL = 32'h0000_048e;

	// ****************************************
	// field layout
	// ****************************************
	localparam int VCC_HALF_W = 32;
	localparam int VCC_REG_W = 64;
	localparam int VCC_BASIC_TRUE_BIT = 55;
	localparam int VCC_SEC_ACTIVATE_BIT = 31;
	localparam logic [31:0] VCC_ZERO_HALF = 32'h0000_0000;
	localparam logic [63:0] VCC_ZERO_REG = 64'h0000_0000_0000_0000;

	// ****************************************
	// reserved-one class members per vector
	// ****************************************
	localparam logic [31:0] VCC_PIN_ONE_CLASS = 32'h0000_0016;
	localparam logic [31:0] VCC_PRIMARY_ONE_CLASS = 32'h0401_e172;

	// ****************************************
	// entry check sequencer states
	// ****************************************
	typedef enum logic [2:0] {
		VCC_IDLE = 3'h1,
		VCC_CHECK = 3'h2,
		VCC_DONE = 3'h4
	} vcc_phase_t;

endpackage

// file: logic/vcc_vec_check.sv
// violation check of one control vector against its allowed settings
`timescale 1ns/1ps
`default_nettype none
module vcc_vec_check (
	input wire logic [31:0] ctl,
	input wire logic [31:0] must_one,
	input wire logic [31:0] may_one,
	input wire logic gate,
	output logic [31:0] bad,
	output logic fail
);
	import vcc_pkg::*;

	// bits forced to one but clear, or set but not allowed
	always_comb begin
		bad = VCC_ZERO_HALF;
		if (gate) begin
			bad = (must_one & ~ctl) | (ctl & ~may_one);
		end
		fail = |bad;
	end

endmodule
`default_nettype wire

// file: logic/vcc_top.sv
// capability registers and guest-entry control validation
`timescale 1ns/1ps
`default_nettype none
module vcc_top #(
	parameter logic TRUE_CTLS = 1'b1,
	parameter logic [31:0] PIN_MUST_ONE = 32'h0000_0000,
	parameter logic [31:0] PIN_MAY_ONE = 32'h0000_00ff,
	parameter logic [31:0] PRIMARY_MUST_ONE = 32'h0000_0000,
	parameter logic [31:0] PRIMARY_MAY_ONE = 32'hffff_fffe,
	parameter logic [31:0] SEC_MAY_ONE = 32'h0000_ffff,
	parameter logic [31:0] SEC_IMPLEMENTED = 32'h0000_ffff
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic cap_rd_req,
	input wire logic cap_wr_req,
	input wire logic [31:0] cap_index,
	output logic cap_ack,
	output logic cap_fault,
	output logic [63:0] cap_rd_data,
	input wire logic entry_req,
	input wire logic [31:0] entry_pin_ctl,
	input wire logic [31:0] entry_primary_ctl,
	input wire logic [31:0] entry_secondary_ctl,
	output logic entry_busy,
	output logic entry_done,
	output logic entry_fail,
	output logic entry_pin_fail,
	output logic entry_primary_fail,
	output logic entry_secondary_fail
);
	import vcc_pkg::*;

	typedef struct packed {
		vcc_phase_t phase;
		logic [31:0] pin_ctl;
		logic [31:0] primary_ctl;
		logic [31:0] secondary_ctl;
		logic fail;
		logic pin_fail;
		logic primary_fail;
		logic secondary_fail;
		logic ack;
		logic fault;
		logic [63:0] data;
	} vcc_state_t;

	// ****************************************
	// capability register contents
	// ****************************************

	// full registers carry the exact allowed settings
	logic [63:0] pin_full;
	logic [63:0] primary_full;
	assign pin_full = {PIN_MAY_ONE, PIN_MUST_ONE};
	assign primary_full = {PRIMARY_MAY_ONE, PRIMARY_MUST_ONE};

	// legacy registers report reserved-one bits as fixed at one
	logic [63:0] pin_legacy;
	logic [63:0] primary_legacy;
	assign pin_legacy = {PIN_MAY_ONE | VCC_PIN_ONE_CLASS,
		PIN_MUST_ONE | VCC_PIN_ONE_CLASS};
	assign primary_legacy = {PRIMARY_MAY_ONE | VCC_PRIMARY_ONE_CLASS,
		PRIMARY_MUST_ONE | VCC_PRIMARY_ONE_CLASS};

	// secondary: low half zero, reserved bits never advertised
	logic [63:0] secondary_caps;
	assign secondary_caps = {SEC_MAY_ONE & SEC_IMPLEMENTED, VCC_ZERO_HALF};

	// secondary register present only when activation may be one
	logic secondary_present;
	assign secondary_present = primary_legacy[VCC_HALF_W + VCC_SEC_ACTIVATE_BIT];

	// ****************************************
	// settings used by validation
	// ****************************************

	// full registers govern when supported, legacy otherwise
	logic [63:0] pin_used;
	logic [63:0] primary_used;
	assign pin_used = TRUE_CTLS ? pin_full : pin_legacy;
	assign primary_used = TRUE_CTLS ? primary_full : primary_legacy;

	vcc_state_t state_reg;
	vcc_state_t state_next;
	logic pin_bad_fail;
	logic primary_bad_fail;
	logic secondary_bad_fail;

	// pin vector check
	vcc_vec_check u_pin (
		.ctl(state_reg.pin_ctl),
		.must_one(pin_used[VCC_HALF_W-1:0]),
		.may_one(pin_used[VCC_REG_W-1:VCC_HALF_W]),
		.gate(1'b1),
		.bad(),
		.fail(pin_bad_fail)
	);

	// primary vector check
	vcc_vec_check u_primary (
		.ctl(state_reg.primary_ctl),
		.must_one(primary_used[VCC_HALF_W-1:0]),
		.may_one(primary_used[VCC_REG_W-1:VCC_HALF_W]),
		.gate(1'b1),
		.bad(),
		.fail(primary_bad_fail)
	);

	// secondary vector check, only under activation
	vcc_vec_check u_secondary (
		.ctl(state_reg.secondary_ctl),
		.must_one(secondary_caps[VCC_HALF_W-1:0]),
		.may_one(secondary_present ? secondary_caps[VCC_REG_W-1:VCC_HALF_W] : VCC_ZERO_HALF),
		.gate(state_reg.primary_ctl[VCC_SEC_ACTIVATE_BIT]),
		.bad(),
		.fail(secondary_bad_fail)
	);

	// ****************************************
	// register read decode
	// ****************************************

	// returns presence of an index and its value
	function automatic logic [64:0] cap_lookup(input logic [31:0] idx);
		logic [64:0] r;
		r = {1'b0, VCC_ZERO_REG};
		unique case (idx)
			VCC_IDX_PIN: r = {1'b1, pin_legacy};
			VCC_IDX_PRIMARY: r = {1'b1, primary_legacy};
			VCC_IDX_SECONDARY: r = {secondary_present, secondary_present ? secondary_caps : VCC_ZERO_REG};
			VCC_IDX_PIN_FULL: r = {TRUE_CTLS, TRUE_CTLS ? pin_full : VCC_ZERO_REG};
			VCC_IDX_PRIMARY_FULL: r = {TRUE_CTLS, TRUE_CTLS ? primary_full : VCC_ZERO_REG};
			default: r = {1'b0, VCC_ZERO_REG};
		endcase
		return r;
	endfunction

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [64:0] hit;
		hit = cap_lookup(cap_index);
		state_next = state_reg;
		state_next.ack = 1'b0;
		state_next.fault = 1'b0;
		// reads answer next cycle, writes always fault
		if (cap_wr_req) begin
			state_next.ack = 1'b1;
			state_next.fault = 1'b1;
			state_next.data = VCC_ZERO_REG;
		end else if (cap_rd_req) begin
			state_next.ack = 1'b1;
			state_next.fault = ~hit[VCC_REG_W];
			state_next.data = hit[VCC_REG_W-1:0];
		end
		// entry check sequencer
		unique case (state_reg.phase)
			VCC_IDLE: begin
				if (entry_req) begin
					state_next.pin_ctl = entry_pin_ctl;
					state_next.primary_ctl = entry_primary_ctl;
					state_next.secondary_ctl = entry_secondary_ctl;
					state_next.phase = VCC_CHECK;
				end
			end
			VCC_CHECK: begin
				state_next.pin_fail = pin_bad_fail;
				state_next.primary_fail = primary_bad_fail;
				state_next.secondary_fail = secondary_bad_fail;
				state_next.fail = pin_bad_fail | primary_bad_fail | secondary_bad_fail;
				state_next.phase = VCC_DONE;
			end
			VCC_DONE: begin
				state_next.phase = VCC_IDLE;
			end
			default: begin
				state_next.phase = VCC_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= '{phase: VCC_IDLE, pin_ctl: VCC_ZERO_HALF, primary_ctl: VCC_ZERO_HALF,
				secondary_ctl: VCC_ZERO_HALF, fail: 1'b0, pin_fail: 1'b0, primary_fail: 1'b0,
				secondary_fail: 1'b0, ack: 1'b0, fault: 1'b0, data: VCC_ZERO_REG};
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign cap_ack = state_reg.ack;
	assign cap_fault = state_reg.fault;
	assign cap_rd_data = state_reg.data;
	assign entry_busy = state_reg.phase != VCC_IDLE;
	assign entry_done = state_reg.phase == VCC_DONE;
	assign entry_fail = state_reg.fail;
	assign entry_pin_fail = state_reg.pin_fail;
	assign entry_primary_fail = state_reg.primary_fail;
	assign entry_secondary_fail = state_reg.secondary_fail;

endmodule
`default_nettype wire

// file: tb/vcc_chk.sv
// port assertions for the capability check block
`timescale 1ns/1ps
`default_nettype none
module vcc_chk import vcc_pkg::*; (
	input wire logic mclk, arst_n, cap_rd_req, cap_wr_req, cap_fault, entry_req,
	input wire logic [31:0] cap_index,
	input wire logic [63:0] cap_rd_data,
	input wire logic cap_ack, entry_busy, entry_done, entry_fail,
	input wire logic entry_pin_fail, entry_primary_fail, entry_secondary_fail
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// entry steps and a plain register read
	sequence s_walk;
		entry_busy ##1 (entry_busy && entry_done) ##1 !entry_busy;
	endsequence
	sequence s_rd(logic [31:0] i);
		cap_rd_req && !cap_wr_req && cap_index == i;
	endsequence
	property p_walk; entry_req && !entry_busy |=> s_walk; endproperty
	property p_ack; cap_rd_req || cap_wr_req |=> cap_ack; endproperty
	property p_ro; cap_wr_req |=> cap_fault && cap_rd_data == VCC_ZERO_REG; endproperty
	property p_sec; s_rd(VCC_IDX_SECONDARY) |=> cap_rd_data[31:0] == VCC_ZERO_HALF; endproperty
	property p_pin; s_rd(VCC_IDX_PIN) |=> &(cap_rd_data[31:0] | ~VCC_PIN_ONE_CLASS); endproperty
	property p_pri; s_rd(VCC_IDX_PRIMARY) |=> &(cap_rd_data[31:0] | ~VCC_PRIMARY_ONE_CLASS);
	endproperty
	property p_or; entry_done |-> entry_fail == |{entry_pin_fail, entry_primary_fail,
		entry_secondary_fail}; endproperty
	property p_hold; !entry_done |-> $stable(entry_fail); endproperty
	a_walk: assert property (p_walk) else $error("entry walk");
	a_ack: assert property (p_ack) else $error("no ack");
	a_ro: assert property (p_ro) else $error("write not faulted");
	a_sec: assert property (p_sec) else $error("secondary low half");
	a_pin: assert property (p_pin) else $error("pin one bits");
	a_pri: assert property (p_pri) else $error("primary one bits");
	a_or: assert property (p_or) else $error("fail merge");
	a_hold: assert property (p_hold) else $error("fail moved");
endmodule
bind vcc_top vcc_chk vcc_chk_i (.mclk, .arst_n, .cap_rd_req, .cap_wr_req, .cap_fault,
	.entry_req, .cap_index, .cap_rd_data, .cap_ack, .entry_busy, .entry_done, .entry_fail,
	.entry_pin_fail, .entry_primary_fail, .entry_secondary_fail);
`default_nettype wire

// file: tb/vcc_sw_model.sv
// software side: proposes control words for guest entry
`timescale 1ns/1ps
`default_nettype none
module vcc_sw_model (
	input wire logic [2:0] sel,
	output logic [31:0] pin,
	output logic [31:0] pri,
	output logic [31:0] sec
);
	// proposals keep defaults; 0, 2, 3, 4 and 6 break them on purpose
	always_comb begin
		pin = (sel == 3'h2) ? 32'h117 : 32'h17;
		pri = (sel == 3'h3) ? 32'h0401e173 : 32'h0401e172;
		pri[31] = (sel == 3'h4) || (sel == 3'h6);
		sec = (sel == 3'h6) ? 32'h8000 : {15'h0, sel[2], 16'h0};
		if (sel == 3'h0) begin
			{pin, pri} = 64'h0;
		end
	end
endmodule
`default_nettype wire

// file: tb/vcc_top_tb.sv
// self-checking bench for the capability check block
`timescale 1ns/1ps
`default_nettype none
module vcc_top_tb;
	import vcc_pkg::*;
	// fail bits {any, pin, primary, secondary} per proposal, proposal 0 leftmost
	localparam logic [27:0] EXP_FULL = 28'h00ca900;
	localparam logic [27:0] EXP_LEG = 28'he0cab0b;
	logic mclk, arst_n, rd, wr, req;
	logic [31:0] idx, pin, pri, sec;
	logic [2:0] sel;
	// each instance drives its own bit, so these are nets
	wire logic [1:0] ack, flt, busy, done;
	wire logic [63:0] dat [2];
	wire logic [3:0] fl [2];
	int bad_count = 0;
	int checked = 0;
	// instance 0 has the full registers, instance 1 the legacy ones only
	for (genvar g = 0; g < 2; g++) begin : g_dut
		vcc_top #(.TRUE_CTLS(g == 0), .PIN_MUST_ONE(g ? 32'h1 : 32'h0),
			.PRIMARY_MAY_ONE(g ? 32'h7ffffffe : 32'hfffffffe), .SEC_MAY_ONE(32'h00ffffff))
			vcc_top_i (.mclk, .arst_n, .cap_rd_req(rd), .cap_wr_req(wr), .cap_index(idx),
			.cap_ack(ack[g]), .cap_fault(flt[g]), .cap_rd_data(dat[g]), .entry_req(req),
			.entry_pin_ctl(pin), .entry_primary_ctl(pri), .entry_secondary_ctl(sec),
			.entry_busy(busy[g]), .entry_done(done[g]), .entry_fail(fl[g][3]),
			.entry_pin_fail(fl[g][2]), .entry_primary_fail(fl[g][1]),
			.entry_secondary_fail(fl[g][0]));
	end
	vcc_sw_model vcc_sw_model_i (.sel, .pin, .pri, .sec);
	task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one register access, answer looked at in its single ack cycle
	task automatic acc(input logic w, input logic [31:0] i, input logic [1:0] f,
		input logic [63:0] d0, input logic [63:0] d1);
		@(posedge mclk);
		wr <= w;
		rd <= ~w;
		idx <= i;
		@(posedge mclk);
		wr <= 1'h0;
		rd <= 1'h0;
		#1;
		chk("ack", 64'(ack), 64'h3);
		chk("fault", 64'(flt), 64'(f));
		chk("data0", dat[0], d0);
		chk("data1", dat[1], d1);
	endtask
	task automatic t_regs();
		acc(1'h0, VCC_IDX_PIN, 2'h0, 64'h000000ff00000016, 64'h000000ff00000017);
		acc(1'h0, VCC_IDX_PRIMARY, 2'h0, 64'hfffffffe0401e172, 64'h7ffffffe0401e172);
		acc(1'h0, VCC_IDX_SECONDARY, 2'h2, 64'h0000ffff00000000, 64'h0);
		acc(1'h0, VCC_IDX_PIN_FULL, 2'h2, 64'h000000ff00000000, 64'h0);
		acc(1'h0, VCC_IDX_PRIMARY_FULL, 2'h2, 64'hfffffffe00000000, 64'h0);
		acc(1'h0, 32'h480, 2'h3, 64'h0, 64'h0);
		acc(1'h1, VCC_IDX_PIN, 2'h3, 64'h0, 64'h0);
	endtask
	// result sits in the cycle after the edge that follows the taking edge
	task automatic fin(input logic [3:0] e0, input logic [3:0] e1);
		#1;
		chk("done", 64'(done), 64'h3);
		chk("busy", 64'(busy), 64'h3);
		chk("fail0", 64'(fl[0]), 64'(e0));
		chk("fail1", 64'(fl[1]), 64'(e1));
	endtask
	task automatic t_entry();
		for (int k = 0; k < 7; k++) begin
			@(posedge mclk);
			sel <= 3'(k);
			req <= 1'h1;
			@(posedge mclk);
			req <= 1'h0;
			@(posedge mclk);
			fin(EXP_FULL[24 - 4 * k +: 4], EXP_LEG[24 - 4 * k +: 4]);
		end
	endtask
	// request held into the busy cycle with a bad proposal must be ignored
	task automatic t_busy();
		@(posedge mclk);
		sel <= 3'h1;
		req <= 1'h1;
		@(posedge mclk);
		sel <= 3'h2;
		@(posedge mclk);
		req <= 1'h0;
		fin(4'h0, 4'h0);
		repeat (2) begin
			@(posedge mclk);
			#1;
			chk("done again", 64'(done), 64'h0);
			chk("busy again", 64'(busy), 64'h0);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		repeat (2000) @(posedge mclk);
		bad_count++;
		conclude();
	end
	initial begin
		{arst_n, rd, wr, req, idx, sel} = '0;
		repeat (8) @(posedge mclk);
		arst_n <= 1'h1;
		t_regs();
		t_entry();
		t_busy();
		conclude();
	end
endmodule
`default_nettype wire
